// File: rtl/lpf_bank.sv
// One I/O bank freeze gate with delayed release
`timescale 1ns/1ns
module lpf_bank #(
   parameter int PINS = 8,
   parameter int DELAY = 1,
   parameter int HOLD_CAPABLE = 0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic frz,
   input wire logic [PINS-1:0] pin_in,
   input wire logic [PINS-1:0] core_out,
   input wire logic [PINS-1:0] core_oe,
   input wire logic [PINS-1:0] pull_en,
   input wire logic [PINS-1:0] hold_cfg,
   output logic [PINS-1:0] core_in,
   output logic [PINS-1:0] pad_out,
   output logic [PINS-1:0] pad_oe,
   output logic frozen
);
   import lpf_pkg::*;
   //**********************************************************
   // Release delay
   //**********************************************************
   logic [CNT_W-1:0] cnt_r; // Counts down after freeze drops
   logic frozen_r; // Bank still frozen
   logic [PINS-1:0] hold_val_r; // Output value captured at entry
   logic [PINS-1:0] hold_oe_r; // Output enable captured at entry
   wire release_now = !frz && frozen_r && (cnt_r == '0);
   // Bank stays frozen for its own delay after the request drops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         frozen_r <= 1'b0;
      end else if (frz) begin
         cnt_r <= CNT_W'(DELAY);
         frozen_r <= 1'b1;
      end else if (release_now) begin
         frozen_r <= 1'b0;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end
   // Latch output state while running so hold mode has a value
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_val_r <= '0;
         hold_oe_r <= '0;
      end else if (!frozen_r && !frz) begin
         hold_val_r <= core_out;
         hold_oe_r <= core_oe;
      end
   end
   //**********************************************************
   // Pad and core views
   //**********************************************************
   // Hold bits keep pad at its captured value and enable; on release the live signal takes over
   wire [PINS-1:0] hold_sel = (HOLD_CAPABLE != 0) ? hold_cfg : '0;
   // Basic variant: tristate unless the pin has a weak pull
   wire [PINS-1:0] frz_oe = (hold_sel & hold_oe_r) | (~hold_sel & pull_en & core_oe);
   wire [PINS-1:0] frz_val = (hold_sel & hold_val_r) | (~hold_sel & core_out);
   // Outputs registered; released bank follows the core directly
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         core_in <= '1;
         pad_out <= '0;
         pad_oe <= '0;
         frozen <= 1'b0;
      end else begin
         core_in <= (frz || frozen_r) ? '1 : pin_in;
         pad_out <= (frz || frozen_r) ? frz_val : core_out;
         pad_oe <= (frz || frozen_r) ? frz_oe : core_oe;
         frozen <= frz || frozen_r;
      end
   end
   // Core view stays high for every cycle the bank sees a freeze
   a_core_high: assert property (@(posedge clk) disable iff (!rst_n)
      $past(frz) |=> (core_in == '1))
      else $error("core input not forced high in freeze");
   // Release lands DELAY+1 cycles after the request drops, still frozen at DELAY; a new
   // freeze abandons the attempt
   a_bank_release: assert property (@(posedge clk) disable iff (!rst_n || frz)
      $fell(frz) |-> ##DELAY frozen_r ##1 !frozen_r)
      else $error("bank released at the wrong time");
endmodule : lpf_bank

// File: rtl/lpf_ctrl.sv
// Top of the low-power freeze controller: request sync, state, staggered release
`timescale 1ns/1ns
module lpf_ctrl #(
   parameter int NUM_BANKS = lpf_pkg::NUM_BANKS,
   parameter int PINS = lpf_pkg::PINS_PER_BANK,
   parameter int HOLD_CAPABLE = 0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic freeze_request_pin,
   input wire logic [NUM_BANKS*PINS-1:0] pin_in,
   input wire logic [NUM_BANKS*PINS-1:0] core_out,
   input wire logic [NUM_BANKS*PINS-1:0] core_oe,
   input wire logic [NUM_BANKS*PINS-1:0] pull_en,
   input wire logic [NUM_BANKS*PINS-1:0] hold_cfg,
   input wire logic [NUM_BANKS-1:0] glb_in,
   input wire logic jtag_cmd_req,
   output logic [NUM_BANKS*PINS-1:0] core_in,
   output logic [NUM_BANKS*PINS-1:0] pad_out,
   output logic [NUM_BANKS*PINS-1:0] pad_oe,
   output logic [NUM_BANKS-1:0] glb_core,
   output logic [NUM_BANKS-1:0] bank_frozen,
   output logic pll_enable,
   output logic jtag_cmd_accept,
   output logic freeze_active
);
   import lpf_pkg::*;
   //**********************************************************
   // Request synchroniser
   //**********************************************************
   logic req_meta_r; // First stage, read only by the second
   logic req_sync_r; // Safe level of the request pin
   // Pin is asynchronous to clk, so two flops before any use
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req_meta_r <= 1'b0;
         req_sync_r <= 1'b0;
      end else begin
         req_meta_r <= freeze_request_pin;
         req_sync_r <= req_meta_r;
      end
   end
   //**********************************************************
   // Mode state machine
   //**********************************************************
   lpf_state_type state_r; // Current mode
   lpf_state_type state_nxt; // Next mode
   logic [NUM_BANKS-1:0] frozen_w; // Per-bank freeze from the gates
   logic glb_frz_r; // Globals forced high
   logic [CNT_W-1:0] glb_cnt_r; // Delay before globals release
   wire any_frozen = (|frozen_w) || glb_frz_r;
   // Level sensitive entry; exit waits for every bank and global
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         LPF_RUN: if (req_sync_r) state_nxt = LPF_FREEZE;
         LPF_FREEZE: if (!req_sync_r) state_nxt = LPF_EXIT;
         LPF_EXIT: begin
            if (req_sync_r) state_nxt = LPF_FREEZE; // Re-entry wins
            else if (!any_frozen) state_nxt = LPF_RUN;
         end
         default: state_nxt = LPF_RUN;
      endcase
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) state_r <= LPF_RUN;
      else state_r <= state_nxt;
   end
   wire in_freeze = (state_r == LPF_FREEZE);
   //**********************************************************
   // Globals release, independent of the bank release
   //**********************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         glb_frz_r <= 1'b0;
         glb_cnt_r <= '0;
      end else if (in_freeze) begin
         glb_frz_r <= 1'b1;
         glb_cnt_r <= CNT_W'(GLOBAL_OFFSET_CYC);
      end else if (glb_cnt_r != '0) begin
         glb_cnt_r <= glb_cnt_r - 1'b1;
      end else begin
         glb_frz_r <= 1'b0;
      end
   end
   // Globals read high while frozen, live afterwards; no gating
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) glb_core <= '1;
      else glb_core <= (glb_frz_r || in_freeze) ? '1 : glb_in;
   end
   //**********************************************************
   // Per-bank gates, each with its own release delay
   //**********************************************************
   genvar b;
   generate
      for (b = 0; b < NUM_BANKS; b++) begin : g_bank
         lpf_bank #(
            .PINS(PINS),
            .DELAY(1 + b * BANK_STAGGER_CYC),
            .HOLD_CAPABLE(HOLD_CAPABLE)
         ) u_bank (
            .clk(clk),
            .rst_n(rst_n),
            .frz(in_freeze),
            .pin_in(pin_in[b*PINS +: PINS]),
            .core_out(core_out[b*PINS +: PINS]),
            .core_oe(core_oe[b*PINS +: PINS]),
            .pull_en(pull_en[b*PINS +: PINS]),
            .hold_cfg(hold_cfg[b*PINS +: PINS]),
            .core_in(core_in[b*PINS +: PINS]),
            .pad_out(pad_out[b*PINS +: PINS]),
            .pad_oe(pad_oe[b*PINS +: PINS]),
            .frozen(frozen_w[b])
         );
         // Bank stagger: a lower bank is never still frozen after a higher one
         if (b > 0) begin : g_order
            a_bank_order: assert property (@(posedge clk) disable iff (!rst_n)
               frozen_w[b - 1] |-> frozen_w[b])
               else $error("banks released out of order");
         end
      end
   endgenerate
   //**********************************************************
   // PLL, JTAG and status outputs
   //**********************************************************
   // PLLs restart only once the whole device is out; user must then
   // wait the lock time before trusting PLL outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pll_enable <= 1'b1;
         jtag_cmd_accept <= 1'b0;
         freeze_active <= 1'b0;
         bank_frozen <= '0;
      end else begin
         pll_enable <= (state_nxt == LPF_RUN);
         // Test logic stays powered but every operation is refused
         jtag_cmd_accept <= jtag_cmd_req && (state_nxt == LPF_RUN) &&
                            (state_r == LPF_RUN);
         freeze_active <= (state_nxt != LPF_RUN);
         bank_frozen <= frozen_w;
      end
   end
   a_pll_off: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == LPF_FREEZE) |-> ##1 !pll_enable)
      else $error("PLL enabled during freeze");
   a_jtag_block: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r != LPF_RUN) |=> !jtag_cmd_accept)
      else $error("JTAG accepted during freeze");
   a_level_entry: assert property (@(posedge clk) disable iff (!rst_n)
      (req_sync_r && state_r == LPF_RUN) |=> (state_r == LPF_FREEZE))
      else $error("freeze not entered on request");
   a_exit_start: assert property (@(posedge clk) disable iff (!rst_n)
      (!req_sync_r && state_r == LPF_FREEZE) |=> (state_r == LPF_EXIT))
      else $error("exit not started on deassert");
   a_glob_release: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(in_freeze) && !req_sync_r |-> ##[1:8] !glb_frz_r)
      else $error("globals not released");
   //**********************************************************
   // Mode checks
   //**********************************************************
   // These watch the mode machine and the globals path from inside, so a
   // broken stagger or a stuck exit shows up at the cycle it happens
   // rather than as a wrong pad value many cycles later.
   // Longest legal stay in exit: last bank delay plus its output flop,
   // the globals offset and a small margin
   localparam int EXIT_MAX = 1 + (NUM_BANKS - 1) * BANK_STAGGER_CYC + GLOBAL_OFFSET_CYC + 2;
   logic [CNT_W-1:0] exit_cnt_r; // Cycles spent in exit so far
   // Counts only while in exit; any other mode clears it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) exit_cnt_r <= '0;
      else if (state_r == LPF_EXIT) exit_cnt_r <= exit_cnt_r + 1'b1;
      else exit_cnt_r <= '0;
   end
   // Exit may not outlast the slowest bank
   a_exit_bound: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == LPF_EXIT) |-> (exit_cnt_r <= CNT_W'(EXIT_MAX)))
      else $error("exit lasted too long");
   // Exit ends once every bank and global is free
   a_exit_done: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == LPF_EXIT && !req_sync_r && !any_frozen) |=> (state_r == LPF_RUN))
      else $error("exit did not finish");
   // Request back during exit returns to freeze
   a_reentry_freeze: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == LPF_EXIT && req_sync_r) |=> in_freeze)
      else $error("freeze not re-entered");
   // Status flag raised for the whole freeze
   a_active_flag: assert property (@(posedge clk) disable iff (!rst_n)
      in_freeze |=> freeze_active)
      else $error("freeze status missing");
   // Status flag dropped once the mode is back to run
   a_active_clear: assert property (@(posedge clk) disable iff (!rst_n)
      (state_nxt == LPF_RUN) |=> !freeze_active)
      else $error("freeze status stuck");
   // PLLs back on as soon as the mode is run again
   a_pll_run: assert property (@(posedge clk) disable iff (!rst_n)
      (state_nxt == LPF_RUN) |=> pll_enable)
      else $error("PLL not restarted");
   // PLLs stay off while any bank or global is still held
   a_pll_exit: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == LPF_EXIT && any_frozen) |=> !pll_enable)
      else $error("PLL enabled during exit");
   // Requests are taken again once the mode is run
   a_jtag_run: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == LPF_RUN && state_nxt == LPF_RUN && jtag_cmd_req) |=> jtag_cmd_accept)
      else $error("JTAG refused while running");
   // Globals are held as soon as the freeze starts
   a_glob_start: assert property (@(posedge clk) disable iff (!rst_n)
      in_freeze |=> glb_frz_r)
      else $error("globals not held");
   // Held globals read high to the core
   a_glob_high: assert property (@(posedge clk) disable iff (!rst_n)
      (in_freeze || glb_frz_r) |=> (glb_core == '1))
      else $error("globals not forced high");
   // Released globals follow their sources, low ones included
   a_glob_follow: assert property (@(posedge clk) disable iff (!rst_n)
      (!in_freeze && !glb_frz_r) |=> (glb_core == $past(glb_in)))
      else $error("globals not following sources");
   // Nothing is left frozen while running
   a_run_clean: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == LPF_RUN) |-> ((frozen_w == '0) && !glb_frz_r))
      else $error("frozen bank while running");
   // The unused state code is never reached
   a_state_legal: assert property (@(posedge clk) disable iff (!rst_n)
      state_r inside {LPF_RUN, LPF_FREEZE, LPF_EXIT})
      else $error("illegal mode state");
endmodule : lpf_ctrl

// File: rtl/lpf_pkg.sv
// Package of constants for the low-power freeze mode controller
//**********************************************************************
// Functional notes
// - PLLs stay off throughout freeze
// - Basic variant: outputs tristate unless pulled
// - Core-facing inputs read high during freeze
// - Hold variant: outputs follow per-pin configuration
// - JTAG refuses all operations during freeze
// - Request stays monitored; deassert starts exit
// - Inputs and globals release independently, staggered
// - I/O banks reactivate at different times
// - Forced-high inputs and globals released on exit
// - Output hold release follows driving signal
//**********************************************************************
package lpf_pkg;
   // Number of I/O banks released one after another
   localparam int NUM_BANKS = 4;
   // Number of pins handled per bank
   localparam int PINS_PER_BANK = 8;
   // Stagger between successive bank releases, in ns
   localparam int BANK_STAGGER_NS = 20;
   // Clock period in ns
   localparam int CLK_PERIOD_NS = 4;
   // Stagger in cycles, rounded down, at least one
   localparam int BANK_STAGGER_CYC = (BANK_STAGGER_NS / CLK_PERIOD_NS) < 1 ? 1 :
      (BANK_STAGGER_NS / CLK_PERIOD_NS);
   // Cycles the globals count down after the freeze ends, before they release
   localparam int GLOBAL_OFFSET_CYC = 2;
   // Width of stagger counters
   localparam int CNT_W = 8;
   // Controller states, Gray along run-freeze-exit path
   typedef enum logic [1:0] {
      LPF_RUN = 2'b00,
      LPF_FREEZE = 2'b01,
      LPF_EXIT = 2'b11
   } lpf_state_type;
endpackage : lpf_pkg

// File: sim/lpf_host_model.sv
// Model of the external controller that drives the freeze request
`timescale 1ns/1ns
module lpf_host_model #(
   parameter int LOCK_WAIT = 30
) (
   input wire logic clk,
   output logic freeze_request_pin
);
   // Idle level is released, so the device starts out running
   initial freeze_request_pin = 1'b0;
   // Level changes only at a falling edge and stay put until told otherwise
   task automatic hold_req(input logic lvl);
      @(negedge clk);
      freeze_request_pin = lvl;
   endtask : hold_req
   // Test clock is never toggled; PLL outputs left alone for the lock time
   task automatic wait_lock();
      repeat (LOCK_WAIT) @(negedge clk);
   endtask : wait_lock
endmodule : lpf_host_model

// File: sim/tb_top.sv
// Self-checking bench for the low-power freeze controller
`timescale 1ns/1ns
module tb_top;
   import lpf_pkg::*;
   localparam int W = NUM_BANKS * PINS_PER_BANK;
   localparam int OW = 11 + 3 * W;
   localparam logic [OW-1:0] ALL = '1;
   // Last bank status and its core view
   localparam logic [OW-1:0] B3_MSK = (OW'(1) << (3 * W + 7)) | (OW'(8'hff) << (2 * W + 24));
   typedef struct {string nm; logic [OW-1:0] exp; logic [OW-1:0] msk;} lpf_note_type;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic freeze_request_pin;
   logic [W-1:0] pin_in = '0, core_out = '0, core_oe = '0, pull_en = '0, hold_cfg = '0;
   logic [3:0] glb_in = 4'h0;
   logic jtag_cmd_req = 1'b1;
   logic [W-1:0] core_in, pad_out, pad_oe;
   logic [3:0] glb_core, bank_frozen;
   logic pll_enable, jtag_cmd_accept, freeze_active;
   int failures = 0;
   int cmp_count = 0;
   lpf_note_type notes[$];
   event probe;
   // Observed view: status, globals, core view, pad enables and pad values
   wire [OW-1:0] obs = {pll_enable, jtag_cmd_accept, freeze_active, bank_frozen,
      glb_core, core_in, pad_oe, pad_out};
   lpf_ctrl u_lpf_ctrl (.clk(clk), .rst_n(rst_n), .freeze_request_pin(freeze_request_pin),
      .pin_in(pin_in), .core_out(core_out), .core_oe(core_oe), .pull_en(pull_en),
      .hold_cfg(hold_cfg), .glb_in(glb_in), .jtag_cmd_req(jtag_cmd_req),
      .core_in(core_in), .pad_out(pad_out), .pad_oe(pad_oe), .glb_core(glb_core),
      .bank_frozen(bank_frozen), .pll_enable(pll_enable),
      .jtag_cmd_accept(jtag_cmd_accept), .freeze_active(freeze_active));
   lpf_host_model u_lpf_host_model (.clk(clk), .freeze_request_pin(freeze_request_pin));
   //**********************************************************************
   // Clock, compare and closing tasks
   //**********************************************************************
   initial forever #2 clk = ~clk;
   task automatic check(input string nm, input logic [OW-1:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // Note the expected view, wake the monitor, then let an edge pass
   task automatic expect_view(input string nm, input logic frz, input logic [OW-1:0] msk);
      lpf_note_type n;
      n.nm = nm;
      n.msk = msk;
      // Frozen basic pads stay driven only where a weak pull is set
      n.exp = frz ? {3'b001, 8'hff, {W{1'b1}}, pull_en & core_oe, core_out} :
         {1'b1, jtag_cmd_req, 1'b0, 4'h0, glb_in, pin_in, core_oe, core_out};
      notes.push_back(n);
      ->probe;
      @(negedge clk);
   endtask : expect_view
   task automatic randomize_io();
      pin_in = W'($urandom);
      core_out = W'($urandom);
      core_oe = W'($urandom);
      pull_en = W'($urandom);
      hold_cfg = W'($urandom);
      glb_in = 4'($urandom);
   endtask : randomize_io
   task automatic finish_test();
      $display("Compares %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : finish_test
   // Monitor: takes the oldest note whenever the driver signals a result
   initial begin : mon
      lpf_note_type n;
      forever begin
         @(probe);
         n = notes.pop_front();
         check(n.nm, obs & n.msk, n.exp & n.msk);
      end
   end
   // Watchdog: whole run is under two hundred cycles, this leaves ample margin
   initial begin
      #20000;
      failures++;
      finish_test();
   end
   //**********************************************************************
   // Main sequence
   //**********************************************************************
   initial begin
      void'($urandom(16558));
      repeat (4) @(negedge clk);
      expect_view("reset", 1'b1, {7'h0, {(OW - 7){1'b1}}});
      rst_n = 1'b1;
      repeat (6) @(negedge clk);
      expect_view("run", 1'b0, ALL);
      for (int r = 0; r < 3; r++) begin
         randomize_io();
         u_lpf_host_model.hold_req(1'b1);
         repeat (8) @(negedge clk);
         expect_view("freeze", 1'b1, ALL);
         // Pads toggle while frozen; core view must stay high
         randomize_io();
         @(negedge clk);
         expect_view("toggle", 1'b1, ALL);
         u_lpf_host_model.hold_req(1'b0);
         // Request returning in mid-exit must bring the freeze back
         if (r == 2) begin
            repeat (3) @(negedge clk);
            u_lpf_host_model.hold_req(1'b1);
            repeat (8) @(negedge clk);
            expect_view("reentry", 1'b1, ALL);
            u_lpf_host_model.hold_req(1'b0);
         end
         for (int i = 0; i < 40 && bank_frozen[0] !== 1'b0; i++) @(negedge clk);
         // Bank 0 free, bank 1 still five cycles from release, globals live
         check("stagger order", bank_frozen, 4'he);
         check("globals free", glb_core, glb_in);
         check("bank0 core view", core_in[7:0], pin_in[7:0]);
         expect_view("stagger", 1'b1, B3_MSK);
         u_lpf_host_model.wait_lock();
         expect_view("exit", 1'b0, ALL);
         $display("Round %0d done", r);
      end
      finish_test();
   end
endmodule : tb_top
